// ==== shared/epr_map.svh ====
// Constants of the execute back end: lanes, stages, widths, encodings.
// Assumes inclusion by the package and the design files by bare name.
`ifndef EPR_MAP_SVH
`define EPR_MAP_SVH
// Lane numbering
`define EPR_NLN   6
`define EPR_A0    0
`define EPR_A1    1
`define EPR_MS    2
`define EPR_BR    3
`define EPR_FA    4
`define EPR_FM    5
// Stage numbering E C M W X T D
`define EPR_NST   7
`define EPR_SE    0
`define EPR_SC    1
`define EPR_SM    2
`define EPR_SW    3
`define EPR_SX    4
`define EPR_ST    5
`define EPR_SD    6
// Widths
`define EPR_DW    32
`define EPR_AGW   6
`define EPR_RW    5
// Load size codes in fn
`define EPR_SZ_B  2'h0
`define EPR_SZ_H  2'h1
`define EPR_SZ_W  2'h2
// Sequential fall-through past branch and delay slot
`define EPR_PC_STEP 32'h8
// Number of helper flows behind a replayed load
`define EPR_NHELP 2
`endif

// ==== shared/epr_pkg.sv ====
// Types and helper functions of the execute back end.
// Assumes epr_map.svh on the include path.
`include "epr_map.svh"
package epr_pkg;

  typedef enum logic [2:0] {
    K_ALU  = 3'h0,  // Single-cycle integer
    K_SIU  = 3'h1,  // Special execution unit
    K_LDU  = 3'h2,  // Doubleword or unsigned word load
    K_LDS  = 3'h3,  // Signed word, halfword, byte load
    K_LDF  = 3'h4,  // Floating-point load
    K_JMPL = 3'h5,  // Register jump or return
    K_BR   = 3'h6,  // Conditional branch
    K_FP   = 3'h7   // Floating-point or graphics op
  } epr_kind_e;

  typedef enum logic [1:0] {
    W_TRAP = 2'h0,
    W_RECIRC = 2'h1,
    W_MISPRED = 2'h2,
    W_JUMP = 2'h3
  } epr_why_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'h0,
    S_HOLD  = 2'h1,
    S_HELP1 = 2'h2,
    S_HELP2 = 2'h3
  } epr_fsm_e;

  // One instruction slot
  typedef struct packed {
    logic                   vld;
    logic                   hlp;   // Helper flow
    logic                   fb;    // Data comes from fill buffer
    logic                   miss;  // Missed, no write-back
    epr_kind_e              kind;
    logic [1:0]             fn;    // ALU op, load size, predicted dir
    logic [`EPR_RW-1:0]     rd;
    logic [`EPR_AGW-1:0]    age;
    logic [`EPR_DW-1:0]     pc;
    logic [`EPR_DW-1:0]     opa;
    logic [`EPR_DW-1:0]     opb;
    logic [`EPR_DW-1:0]     res;
  } epr_uop_s;

  // Result write or bypass
  typedef struct packed {
    logic               vld;
    logic [`EPR_RW-1:0] rd;
    logic [`EPR_DW-1:0] dat;
  } epr_wb_s;

  // Memory side request
  typedef struct packed {
    logic               vld;
    logic [`EPR_DW-1:0] addr;
  } epr_req_s;

  // Fetch redirect
  typedef struct packed {
    logic               vld;
    epr_why_e           why;
    logic [`EPR_DW-1:0] pc;
  } epr_redir_s;

  // True if age a is cancelled by a kill at age k
  function automatic logic epr_dies(input logic [`EPR_AGW-1:0] a,
                                    input logic [`EPR_AGW-1:0] k,
                                    input logic incl);
    logic signed [`EPR_AGW-1:0] d;
    d = $signed(a - k);
    return incl ? (d >= 0) : (d > 0);
  endfunction

  // Integer ALU: add, shift left, and, xor
  function automatic logic [`EPR_DW-1:0] epr_alu(input logic [1:0] fn,
                                                 input logic [`EPR_DW-1:0] a,
                                                 input logic [`EPR_DW-1:0] b);
    unique case (fn)
      2'h0: return a + b;
      2'h1: return a << b[4:0];
      2'h2: return a & b;
      2'h3: return a ^ b;
    endcase
  endfunction

  // Align and sign extend a loaded value
  function automatic logic [`EPR_DW-1:0] epr_sext(input logic [1:0] sz,
                                                  input logic [`EPR_DW-1:0] d);
    if (sz == `EPR_SZ_B) return {{24{d[7]}}, d[7:0]};
    if (sz == `EPR_SZ_H) return {{16{d[15]}}, d[15:0]};
    return d;
  endfunction

endpackage

// ==== design/epr_lane.sv ====
// One execution lane: seven stage slots advancing each clock.
// Assumes the caller supplies per-stage result updates and the kill.
`timescale 1ns/10ps
`default_nettype none
`include "epr_map.svh"
module epr_lane
  import epr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Entry and per-transfer updates
  input  wire epr_uop_s in_uop,
  input  wire logic upd_vld [`EPR_NST-1],
  input  wire epr_uop_s upd_val [`EPR_NST-1],
  // Cancellation
  input  wire logic                kill,
  input  wire logic [`EPR_AGW-1:0] kill_age,
  input  wire logic                kill_incl,
  // Stage contents
  output epr_uop_s  st [`EPR_NST]
);

  epr_uop_s nxt [`EPR_NST-1];

  // Next slot contents with kill applied
  always_comb begin
    for (int i = 0; i < `EPR_NST-1; i++) begin
      nxt[i] = upd_vld[i] ? upd_val[i] : st[i];
      if (kill && epr_dies(nxt[i].age, kill_age, kill_incl)) begin
        nxt[i].vld = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < `EPR_NST; i++) st[i] <= '0;
    end else begin
      st[0] <= in_uop;
      for (int i = 0; i < `EPR_NST-1; i++) st[i+1] <= nxt[i];
    end
  end

endmodule // epr_lane
`default_nettype wire

// ==== design/epr_exec_pipe.sv ====
// Back-end control of six execution lanes, traps and recirculation.
// Assumes dispatch presents aged groups; caches answer in stage.
// How it works
// - ALU lanes compute in E and alone bypass E results to dispatch
// - Special-lane integer ops never bypass before C or M
// - Special-lane loads start cache access and address in E
// - FP lanes read FP registers in E, late FP results bypass there
// - Branches resolve in E; mismatch redirects fetch
// - Jumps and returns compute target in E and redirect fetch
// - Doubleword and unsigned word loads return data in C
// - TLB lookup and FP-load prefetch access start in C, answer in M
// - Special unit results bypass at end of C, two cycles latency
// - ALU lanes write working registers in C
// - FP ops execute in C, M, W and finish in X
// - Miss found in M comparing TLB address with tag address
// - Signed loads aligned in M; load data reaches FP lanes in M
// - Special lane writes working registers in W; misses go to L2
// - FP results leaving X bypass to ops entering C next cycle
// - Trap or recirculation copies committed registers to working file
// - Trap in T cancels trapping and younger ops before D
// - D commits integer and FP results
// - Late dependency recirculates: redirect, cancel ops younger than offender
// - Offender replays alone, held in dispatch until resolved
// - Missed load replays from fill buffer followed by two helpers
// - A helper leaves dispatch alone
`timescale 1ns/10ps
`default_nettype none
`include "epr_map.svh"
module epr_exec_pipe
  import epr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Dispatch side
  input  wire epr_uop_s disp_uop [`EPR_NLN],
  input  wire logic disp_dep,
  output logic      disp_open_reg,
  output logic      disp_alone_reg,
  // Cache, TLB and fill answers
  input  wire logic [`EPR_DW-1:0] dc_data,
  input  wire logic [`EPR_DW-1:0] fill_data,
  input  wire logic               fill_ready,
  input  wire logic [`EPR_DW-1:0] tlb_pa,
  input  wire logic [`EPR_DW-1:0] tag_pa,
  input  wire logic [`EPR_DW-1:0] siu_res,
  input  wire logic [`EPR_DW-1:0] fpu_res [2],
  // Traps at T
  input  wire logic [`EPR_NLN-1:0] trap_hit,
  input  wire logic [`EPR_DW-1:0]  trap_pc,
  // Bypass and register-file writes
  output epr_wb_s   byp_a_reg [2],
  output epr_wb_s   ms_byp_c_reg,
  output epr_wb_s   ms_byp_m_reg,
  output epr_wb_s   fp_byp_reg [2],
  output epr_wb_s   fp_ld_reg,
  output logic [1:0] frf_rd_reg,
  output epr_wb_s   wrf_a_reg [2],
  output epr_wb_s   wrf_ms_reg,
  output epr_wb_s   arf_wr_reg [3],
  output epr_wb_s   frf_wr_reg [3],
  output logic      wrf_copy_reg,
  // Memory requests
  output epr_req_s  dc_req_reg,
  output epr_req_s  tlb_req_reg,
  output epr_req_s  pc_req_reg,
  output epr_req_s  l2_req_reg,
  output logic      dc_fill_reg,
  // Fetch redirect
  output epr_redir_s fetch_reg
);

  epr_uop_s            st [`EPR_NLN][`EPR_NST];
  epr_uop_s            in_uop [`EPR_NLN];
  epr_uop_s            upd [`EPR_NLN][`EPR_NST-1];
  logic                updv [`EPR_NLN][`EPR_NST-1];
  epr_fsm_e            fsm_reg, fsm_next;
  logic [`EPR_AGW-1:0] hold_age_reg;
  logic [`EPR_DW-1:0]  hold_pc_reg;
  logic                t_any, miss_now, rec, kill, go;
  logic [`EPR_AGW-1:0] t_age, kill_age;
  epr_uop_s            me, ce, be, ms_c, ms_m, ms_w;

  function automatic logic is_ld(input epr_uop_s u);
    return u.kind == K_LDU || u.kind == K_LDS || u.kind == K_LDF;
  endfunction

  function automatic logic is_int(input epr_uop_s u);
    return u.kind != K_LDF && u.kind != K_BR && u.kind != K_FP;
  endfunction

  function automatic epr_wb_s wb(input logic v, input epr_uop_s u,
                                 input logic [`EPR_DW-1:0] d);
    return '{vld: v, rd: u.rd, dat: d};
  endfunction

  assign me   = st[`EPR_MS][`EPR_SE];
  assign ce   = st[`EPR_MS][`EPR_SC];
  assign be   = st[`EPR_BR][`EPR_SE];
  assign ms_c = st[`EPR_MS][`EPR_SC];
  assign ms_m = st[`EPR_MS][`EPR_SM];
  assign ms_w = st[`EPR_MS][`EPR_SW];

  always_comb begin
    t_any = 1'b0;
    t_age = '0;
    for (int l = 0; l < `EPR_NLN; l++) begin
      if (st[l][`EPR_ST].vld && trap_hit[l] &&
          (!t_any || epr_dies(t_age, st[l][`EPR_ST].age, 1'b0))) begin
        t_any = 1'b1;
        t_age = st[l][`EPR_ST].age;
      end
    end
  end

  assign miss_now = ms_m.vld && !ms_m.hlp && !ms_m.fb && is_ld(ms_m) && (tlb_pa != tag_pa);
  // recirculate unless an older trap flushes anyway
  assign rec      = miss_now && !t_any;
  assign kill     = t_any || rec;
  assign kill_age = t_any ? t_age : ms_m.age;

  // Recirculation sequence
  always_comb begin
    fsm_next = fsm_reg;
    unique case (fsm_reg)
      S_IDLE:  if (rec) fsm_next = S_HOLD;
      S_HOLD:  if (t_any) fsm_next = S_IDLE;
               else if (fill_ready && disp_uop[`EPR_MS].vld) fsm_next = S_HELP1;
      S_HELP1: fsm_next = t_any ? S_IDLE : S_HELP2;
      S_HELP2: fsm_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) fsm_reg <= S_IDLE;
    else fsm_reg <= fsm_next;
  end

  // Offender identity for the helpers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_age_reg <= '0;
      hold_pc_reg  <= '0;
    end else if (rec) begin
      hold_age_reg <= ms_m.age;
      hold_pc_reg  <= ms_m.pc;
    end
  end

  // dispatch dependency stalls the whole group
  assign go = fsm_reg == S_IDLE && !disp_dep && !kill;

  // Lane entry
  always_comb begin
    for (int l = 0; l < `EPR_NLN; l++) in_uop[l] = go ? disp_uop[l] : '0;
    // replay alone, only once the fill is there
    if (fsm_reg == S_HOLD && fill_ready && !kill) begin
      in_uop[`EPR_MS]    = disp_uop[`EPR_MS];
      in_uop[`EPR_MS].fb = 1'b1;
    end
    // two helpers follow the replayed load
    // nothing else enters beside a helper
    if ((fsm_reg == S_HELP1 || fsm_reg == S_HELP2) && !kill) begin
      in_uop[`EPR_MS]      = '0;
      in_uop[`EPR_MS].vld  = 1'b1;
      in_uop[`EPR_MS].hlp  = 1'b1;
      in_uop[`EPR_MS].kind = K_LDU;
      in_uop[`EPR_MS].age  = hold_age_reg;
      in_uop[`EPR_MS].pc   = hold_pc_reg;
    end
  end

  // Results written into slots as ops move on
  always_comb begin
    for (int l = 0; l < `EPR_NLN; l++) begin
      for (int i = 0; i < `EPR_NST-1; i++) begin
        updv[l][i] = 1'b0;
        upd[l][i]  = st[l][i];
      end
    end
    for (int l = `EPR_A0; l <= `EPR_A1; l++) begin
      updv[l][`EPR_SE]    = st[l][`EPR_SE].kind == K_ALU;
      upd[l][`EPR_SE].res = epr_alu(st[l][`EPR_SE].fn, st[l][`EPR_SE].opa, st[l][`EPR_SE].opb);
    end
    // Link value and load address captured in E
    updv[`EPR_MS][`EPR_SE] = me.kind == K_JMPL || is_ld(me);
    upd[`EPR_MS][`EPR_SE].res = me.kind == K_JMPL ? me.pc : me.opa + me.opb;
    upd[`EPR_MS][`EPR_SE].opb = me.opa + me.opb;
    // load data and special result taken in C
    updv[`EPR_MS][`EPR_SC] = is_ld(ce) || ce.kind == K_SIU;
    upd[`EPR_MS][`EPR_SC].res = ce.kind == K_SIU ? siu_res : (ce.fb ? fill_data : dc_data);
    // sign extension in M, miss flag carried on
    updv[`EPR_MS][`EPR_SM] = 1'b1;
    upd[`EPR_MS][`EPR_SM].miss = miss_now;
    if (ms_m.kind == K_LDS) upd[`EPR_MS][`EPR_SM].res = epr_sext(ms_m.fn, ms_m.res);
    // FP result ready at the end of W, final in X
    for (int f = 0; f < 2; f++) begin
      updv[`EPR_FA+f][`EPR_SW]    = 1'b1;
      upd[`EPR_FA+f][`EPR_SW].res = fpu_res[f];
    end
  end

  for (genvar g = 0; g < `EPR_NLN; g++) begin : g_lane
    epr_lane u_lane (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_uop    (in_uop[g]),
      .upd_vld   (updv[g]),
      .upd_val   (upd[g]),
      .kill      (kill),
      .kill_age  (kill_age),
      .kill_incl (t_any),
      .st        (st[g])
    );
  end

  // Dispatch status for the coming cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      disp_open_reg  <= 1'b1;
      disp_alone_reg <= 1'b0;
    end else begin
      disp_open_reg  <= fsm_next == S_IDLE;
      disp_alone_reg <= fsm_next == S_HOLD;
    end
  end

  // Early bypass and working-file writes of the ALU lanes
  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < 2; l++) begin
      if (!rst_n) begin
        byp_a_reg[l] <= '0;
        wrf_a_reg[l] <= '0;
      end else begin
        // E-stage bypass only from ALU lanes
        byp_a_reg[l] <= wb(st[l][`EPR_SE].vld && st[l][`EPR_SE].kind == K_ALU, st[l][`EPR_SE],
                           epr_alu(st[l][`EPR_SE].fn, st[l][`EPR_SE].opa, st[l][`EPR_SE].opb));
        wrf_a_reg[l] <= wb(st[l][`EPR_SC].vld && st[l][`EPR_SC].kind == K_ALU,
                           st[l][`EPR_SC], st[l][`EPR_SC].res);
      end
    end
  end

  // Special-lane results
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ms_byp_c_reg <= '0;
      ms_byp_m_reg <= '0;
      wrf_ms_reg   <= '0;
      fp_ld_reg    <= '0;
    end else begin
      ms_byp_c_reg <= wb(ms_c.vld && !ms_c.hlp && (ms_c.kind == K_LDU || ms_c.kind == K_SIU), ms_c,
                         ms_c.kind == K_SIU ? siu_res : (ms_c.fb ? fill_data : dc_data));
      ms_byp_m_reg <= wb(ms_m.vld && !ms_m.hlp && !miss_now && (ms_m.kind == K_LDS || ms_m.kind == K_JMPL),
                         ms_m, ms_m.kind == K_LDS ? epr_sext(ms_m.fn, ms_m.res) : ms_m.res);
      fp_ld_reg    <= wb(ms_m.vld && !miss_now && ms_m.kind == K_LDF, ms_m, ms_m.res);
      wrf_ms_reg   <= wb(ms_w.vld && !ms_w.hlp && !ms_w.miss && is_int(ms_w), ms_w, ms_w.res);
    end
  end

  // FP operand reads and late bypass
  always_ff @(posedge clk_sys) begin
    for (int f = 0; f < 2; f++) begin
      if (!rst_n) begin
        frf_rd_reg[f] <= 1'b0;
        fp_byp_reg[f] <= '0;
      end else begin
        frf_rd_reg[f] <= st[`EPR_FA+f][`EPR_SE].vld;
        // X result to ops entering C
        fp_byp_reg[f] <= wb(st[`EPR_FA+f][`EPR_SX].vld, st[`EPR_FA+f][`EPR_SX], st[`EPR_FA+f][`EPR_SX].res);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < 3; l++) begin
      if (!rst_n) begin
        arf_wr_reg[l] <= '0;
        frf_wr_reg[l] <= '0;
      end else begin
        arf_wr_reg[l] <= wb(st[l][`EPR_SD].vld && !st[l][`EPR_SD].hlp && !st[l][`EPR_SD].miss &&
                            is_int(st[l][`EPR_SD]), st[l][`EPR_SD], st[l][`EPR_SD].res);
        if (l == `EPR_MS) begin
          frf_wr_reg[l] <= wb(st[l][`EPR_SD].vld && !st[l][`EPR_SD].miss && st[l][`EPR_SD].kind == K_LDF,
                              st[l][`EPR_SD], st[l][`EPR_SD].res);
        end else begin
          frf_wr_reg[l] <= wb(st[`EPR_FA+l%2][`EPR_SD].vld, st[`EPR_FA+l%2][`EPR_SD], st[`EPR_FA+l%2][`EPR_SD].res);
        end
      end
    end
  end

  // Memory-side requests
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dc_req_reg  <= '0;
      tlb_req_reg <= '0;
      pc_req_reg  <= '0;
      l2_req_reg  <= '0;
      dc_fill_reg <= 1'b0;
    end else begin
      dc_req_reg  <= '{vld: me.vld && !me.hlp && !me.fb && is_ld(me), addr: me.opa + me.opb};
      // TLB and prefetch access from C
      tlb_req_reg <= '{vld: ce.vld && !ce.hlp && !ce.fb && is_ld(ce), addr: ce.opb};
      pc_req_reg  <= '{vld: ce.vld && !ce.fb && ce.kind == K_LDF, addr: ce.opb};
      // missed load asks L2 from W
      l2_req_reg  <= '{vld: ms_w.vld && ms_w.miss, addr: ms_w.opb};
      dc_fill_reg <= me.vld && me.hlp;
    end
  end

  // working file restored on any flush
  always_ff @(posedge clk_sys) begin
    if (!rst_n) wrf_copy_reg <= 1'b0;
    else wrf_copy_reg <= kill;
  end

  // Fetch redirect, trap first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fetch_reg <= '0;
    end else if (t_any) begin
      fetch_reg <= '{vld: 1'b1, why: W_TRAP, pc: trap_pc};
    end else if (rec) begin
      fetch_reg <= '{vld: 1'b1, why: W_RECIRC, pc: ms_m.pc};
    end else if (be.vld && be.kind == K_BR && be.opa[0] != be.fn[0]) begin
      fetch_reg <= '{vld: 1'b1, why: W_MISPRED, pc: be.opa[0] ? be.opb : be.pc + `EPR_PC_STEP};
    end else if (me.vld && me.kind == K_JMPL) begin
      fetch_reg <= '{vld: 1'b1, why: W_JUMP, pc: me.opa + me.opb};
    end else begin
      fetch_reg <= '0;
    end
  end

  a_alu_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st[0][`EPR_SE].vld && st[0][`EPR_SE].kind == K_ALU |=> byp_a_reg[0].vld)
    else $error("ALU E result not bypassed");
  a_siu_late: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ms_c.vld && ms_c.kind == K_SIU |=> ms_byp_c_reg.vld && ms_byp_c_reg.dat == $past(siu_res))
    else $error("special result not bypassed from C");
  a_load_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    me.vld && me.kind == K_LDU && !me.hlp && !me.fb |=> dc_req_reg.vld)
    else $error("load did not start cache access in E");
  a_branch_miss: assert property (@(posedge clk_sys) disable iff (!rst_n)
    be.vld && be.kind == K_BR && be.opa[0] != be.fn[0] |=> fetch_reg.vld)
    else $error("mispredict not sent to fetch");
  a_flush_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rec |=> wrf_copy_reg ##1 !$past(kill) || wrf_copy_reg)
    else $error("flush without register copy");
  a_trap_cancel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st[1][`EPR_ST].vld && trap_hit[1] |=> !st[1][`EPR_SD].vld ##1 !arf_wr_reg[1].vld)
    else $error("trapping op reached commit");
  a_help_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fsm_reg == S_HOLD && fsm_next == S_HELP1 && !kill |=> me.fb ##1 me.hlp ##1 me.hlp)
    else $error("replayed load not followed by two helpers");
  a_help_solo: assert property (@(posedge clk_sys) disable iff (!rst_n)
    me.vld && me.hlp |-> !st[0][`EPR_SE].vld && !st[1][`EPR_SE].vld && !be.vld &&
    !st[`EPR_FA][`EPR_SE].vld && !st[`EPR_FM][`EPR_SE].vld)
    else $error("instruction issued beside a helper");
  a_lane_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st[0][`EPR_SC].vld && !kill |=> st[0][`EPR_SM].vld && st[0][`EPR_SM].age == $past(st[0][`EPR_SC].age))
    else $error("op did not advance one stage");

endmodule // epr_exec_pipe
`default_nettype wire

// ==== verif/epr_far_end.sv ====
// Far-side model: data cache, TLB, fill buffer, special unit, FP units.
// Assumes requests come registered from the back end on one clock.
`timescale 1ns/10ps
`default_nettype none
`include "epr_map.svh"
module epr_far_end
  import epr_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  // Requests and test controls
  input  wire epr_req_s dc_req,
  input  wire epr_req_s l2_req,
  input  wire logic   miss_en,
  input  wire logic   slow,
  // Answers
  output logic [31:0] dc_data,
  output logic [31:0] tlb_pa,
  output logic [31:0] tag_pa,
  output logic [31:0] fill_data,
  output logic        fill_ready,
  output logic [31:0] siu_res,
  output logic [31:0] fpu_res [2]
);
  logic [31:0] cnt_reg;
  logic [31:0] pa_reg;
  logic [4:0]  wait_reg;
  // Free counter, so idle answers move every cycle
  always_ff @(posedge clk_sys) begin
    cnt_reg <= rst_n ? cnt_reg + 32'h1 : 32'h0;
  end
  // Load address kept one cycle for the tag compare
  always_ff @(posedge clk_sys) begin
    pa_reg <= dc_req.vld ? dc_req.addr : cnt_reg * 32'h9e37_79b1;
  end
  // Fill data shows up after a short or long wait
  always_ff @(posedge clk_sys) begin
    if (!rst_n || l2_req.vld) begin
      fill_ready <= 1'b0;
      wait_reg   <= rst_n ? (slow ? 5'h0c : 5'h02) : 5'h00;
      fill_data  <= l2_req.addr ^ 32'h5a5a_0f0f;
    end else if (wait_reg != 5'h00) begin
      wait_reg   <= wait_reg - 5'h01;
      fill_ready <= (wait_reg == 5'h01);
    end
  end
  // Read data while a load reads, inverted held address otherwise
  assign dc_data    = dc_req.vld ? dc_req.addr ^ 32'h5a5a_0f0f : ~pa_reg;
  assign tlb_pa     = pa_reg;
  assign tag_pa     = miss_en ? ~pa_reg : pa_reg; // Miss on command
  assign siu_res    = cnt_reg ^ 32'h0f0f_3c3c;
  assign fpu_res[0] = cnt_reg * 32'h3;
  assign fpu_res[1] = ~cnt_reg;
endmodule // epr_far_end
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench of the execute back end.
// Assumes the package, design and far-side model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "epr_map.svh"
module tb_top
  import epr_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        disp_dep, disp_open_reg, disp_alone_reg, fill_ready, wrf_copy_reg, dc_fill_reg, miss_en, slow;
  logic [31:0] dc_data, fill_data, tlb_pa, tag_pa, siu_res, trap_pc, fpu_res [2];
  logic [5:0]  trap_hit, age;
  logic [1:0]  frf_rd_reg;
  epr_uop_s    disp_uop [`EPR_NLN];
  epr_wb_s     byp_a_reg [2], fp_byp_reg [2], wrf_a_reg [2], arf_wr_reg [3], frf_wr_reg [3];
  epr_wb_s     ms_byp_c_reg, ms_byp_m_reg, fp_ld_reg, wrf_ms_reg;
  epr_req_s    dc_req_reg, tlb_req_reg, pc_req_reg, l2_req_reg;
  epr_redir_s  fetch_reg;
  logic [31:0] seed = 32'h8031;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  epr_exec_pipe epr_exec_pipe_inst (.clk_sys, .rst_n, .disp_uop, .disp_dep, .disp_open_reg, .disp_alone_reg,
    .dc_data, .fill_data, .fill_ready, .tlb_pa, .tag_pa, .siu_res, .fpu_res, .trap_hit, .trap_pc, .byp_a_reg,
    .ms_byp_c_reg, .ms_byp_m_reg, .fp_byp_reg, .fp_ld_reg, .frf_rd_reg, .wrf_a_reg, .wrf_ms_reg, .arf_wr_reg,
    .frf_wr_reg, .wrf_copy_reg, .dc_req_reg, .tlb_req_reg, .pc_req_reg, .l2_req_reg, .dc_fill_reg, .fetch_reg);
  epr_far_end epr_far_end_inst (.clk_sys, .rst_n, .dc_req(dc_req_reg), .l2_req(l2_req_reg), .miss_en, .slow,
    .dc_data, .tlb_pa, .tag_pa, .fill_data, .fill_ready, .siu_res, .fpu_res);
  // Clock, and a ceiling on run length
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      close_out();
    end
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Build one valid op with the next age
  function automatic epr_uop_s mk(epr_kind_e k, logic [1:0] f, logic [31:0] a, logic [31:0] b);
    logic [31:0] p;
    p = rnd();
    mk = '0;
    mk.vld = 1'b1;
    mk.kind = k;
    mk.fn = f;
    mk.rd = a[4:0];
    mk.age = age;
    mk.pc = {p[31:2], 2'h0};
    mk.opa = a;
    mk.opb = b;
    age = age + 6'h1;
  endfunction
  function automatic epr_wb_s wb(logic [4:0] r, logic [31:0] d);
    return {1'b1, r, d};
  endfunction
  function automatic logic [31:0] alu(logic [1:0] f, logic [31:0] a, logic [31:0] b);
    case (f)
      2'h0: return a + b;
      2'h1: return a << b[4:0];
      2'h2: return a & b;
      default: return a ^ b;
    endcase
  endfunction
  function automatic logic [31:0] sx(logic [1:0] s, logic [31:0] d);
    if (s == 2'h0) return {{24{d[7]}}, d[7:0]};
    if (s == 2'h1) return {{16{d[15]}}, d[15:0]};
    return d;
  endfunction
  task automatic chk(logic [63:0] g, logic [63:0] e, string m);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Present one op for one cycle; returns in its E cycle
  task automatic put(int ln, epr_uop_s u);
    disp_uop[ln] = u;
    step(1);
    disp_uop[ln] = '0;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    epr_uop_s u;
    logic [31:0] a, b, x;
    int n, k;
    disp_uop = '{default: '0};
    {disp_dep, miss_en, slow, trap_hit, age} = '0;
    trap_pc = 32'h0000_0400;
    step(4);
    rst_n = 1'b1;
    step(1);
    chk({disp_open_reg, disp_alone_reg, fetch_reg.vld, wrf_copy_reg}, 4'h8, "reset");
    for (n = 0; n < 8; n++) begin
      a = (n == 0) ? 32'hffff_ffff : rnd();
      b = (n == 0) ? 32'h1 : rnd();
      u = mk(K_ALU, n[2:1], a, b);
      put(n % 2, u);
      step(1);
      chk(byp_a_reg[n % 2], wb(u.rd, alu(u.fn, a, b)), "alu byp");
      step(1);
      chk(wrf_a_reg[n % 2], wb(u.rd, alu(u.fn, a, b)), "alu wrf");
      step(5);
      chk(arf_wr_reg[n % 2], wb(u.rd, alu(u.fn, a, b)), "alu arf");
    end
    u = mk(K_SIU, 2'h0, rnd(), rnd());
    put(2, u);
    step(1);
    chk(ms_byp_c_reg.vld, 1'b0, "siu early");
    x = siu_res;
    step(1);
    chk(ms_byp_c_reg, wb(u.rd, x), "siu byp");
    a = rnd();
    b = rnd();
    u = mk(K_LDU, 2'h2, a, b);
    put(2, u);
    step(1);
    chk(dc_req_reg, {1'b1, a + b}, "ld addr");
    step(1);
    chk(ms_byp_c_reg, wb(u.rd, (a + b) ^ 32'h5a5a_0f0f), "ldu data");
    chk(tlb_req_reg.vld, 1'b1, "tlb");
    step(2);
    chk(wrf_ms_reg, wb(u.rd, (a + b) ^ 32'h5a5a_0f0f), "ms wrf");
    step(3);
    chk(arf_wr_reg[2], wb(u.rd, (a + b) ^ 32'h5a5a_0f0f), "ms arf");
    for (n = 0; n < 3; n++) begin
      a = rnd();
      u = mk(K_LDS, n[1:0], a, 32'h0);
      put(2, u);
      step(3);
      chk(ms_byp_m_reg, wb(u.rd, sx(n[1:0], a ^ 32'h5a5a_0f0f)), "lds");
    end
    u = mk(K_LDF, 2'h2, rnd(), 32'h0);
    put(2, u);
    step(2);
    chk(pc_req_reg.vld, 1'b1, "pcache");
    step(1);
    chk(fp_ld_reg.vld, 1'b1, "fp ld");
    step(4);
    chk(frf_wr_reg[2].vld, 1'b1, "fp ld commit");
    for (n = 4; n < 6; n++) begin
      u = mk(K_FP, 2'h0, rnd(), rnd());
      put(n, u);
      step(1);
      chk(frf_rd_reg[n - 4], 1'b1, "fp read");
      step(2);
      x = fpu_res[n - 4];
      step(2);
      chk(fp_byp_reg[n - 4], wb(u.rd, x), "fp byp");
      step(2);
      chk(frf_wr_reg[n - 4], wb(u.rd, x), "fp commit");
    end
    for (n = 0; n < 3; n++) begin
      b = rnd();
      u = mk(K_BR, {1'b0, n != 0}, {31'h0, n != 1}, b);
      put(3, u);
      step(1);
      if (n == 2) chk(fetch_reg.vld, 1'b0, "br ok");
      else chk(fetch_reg, {1'b1, W_MISPRED, n ? u.pc + `EPR_PC_STEP : b}, "br miss");
    end
    put(2, mk(K_JMPL, 2'h0, rnd(), rnd()));
    step(1);
    chk({fetch_reg.vld, fetch_reg.why}, {1'b1, W_JUMP}, "jump");
    disp_dep = 1'b1;
    put(0, mk(K_ALU, 2'h0, rnd(), rnd()));
    disp_dep = 1'b0;
    step(1);
    chk(byp_a_reg[0].vld, 1'b0, "stall");
    put(1, mk(K_ALU, 2'h3, rnd(), rnd()));
    step(5);
    trap_hit = 6'h02;
    step(1);
    trap_hit = 6'h00;
    chk(fetch_reg, {1'b1, W_TRAP, trap_pc}, "trap");
    chk(wrf_copy_reg, 1'b1, "trap copy");
    step(1);
    chk(arf_wr_reg[1].vld, 1'b0, "trap cancel");
    {miss_en, slow} = 2'h3;
    u = mk(K_LDU, 2'h2, rnd(), rnd());
    put(2, u);
    step(3);
    miss_en = 1'b0;
    chk(fetch_reg, {1'b1, W_RECIRC, u.pc}, "recirc");
    chk({wrf_copy_reg, disp_open_reg, disp_alone_reg}, 3'h5, "hold");
    step(1);
    chk(l2_req_reg.vld, 1'b1, "l2");
    disp_uop[2] = u;
    disp_uop[0] = mk(K_ALU, 2'h0, rnd(), rnd());
    for (n = 0; n < 60 && fill_ready !== 1'b1; n++) step(1);
    x = fill_data;
    step(1);
    disp_uop = '{default: '0};
    {n, k} = '0;
    for (int i = 2; i < 12; i++) begin
      step(1);
      if (dc_fill_reg === 1'b1) n++;
      if (byp_a_reg[0].vld === 1'b1) k++;
      if (i == 3) chk(ms_byp_c_reg, wb(u.rd, x), "fill data");
    end
    chk(n, 2, "helpers");
    chk(k, 0, "alone");
    chk({disp_open_reg, disp_alone_reg}, 2'h2, "reopen");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
